// ---- rtl/usb_bk_pkg.sv ----
// package: constants, register map and carrier types for the usb bookkeeping block
// assumes one clock domain shared by the core register bus and the serial engine
package usb_bk_pkg;
	localparam int unsigned CLK_NS        = 10;
	localparam int unsigned TCY_NS        = 40;
	localparam int unsigned REFLAG_TCY    = 5;
	localparam int unsigned REFLAG_CYCLES = (REFLAG_TCY * TCY_NS) / CLK_NS;

	localparam int unsigned NUM_EP     = 16;
	localparam int unsigned FIFO_DEPTH = 4;
	localparam int unsigned BD_MAX     = 64;
	localparam int unsigned BD_BYTES   = 4;

	// byte addresses on the register bus
	localparam logic [12:0] OFF_STATUS   = 13'h0000;
	localparam logic [12:0] OFF_FLAGS    = 13'h0004;
	localparam logic [12:0] OFF_DEV_ADDR = 13'h0008;
	localparam logic [12:0] OFF_FRAME_LO = 13'h000c;
	localparam logic [12:0] OFF_FRAME_HI = 13'h0010;
	localparam logic [12:0] OFF_EP_CTL   = 13'h0040;

	// word indices of the shared buffer memory, byte address is four times
	localparam logic [10:0] RAM_FIRST_IDX = 11'h400;
	localparam logic [10:0] RAM_LAST_IDX  = 11'h7ff;
	localparam logic [10:0] DESC_LAST_IDX = 11'h4ff;

	// status window fields
	localparam int unsigned ST_EP_LSB = 3;
	localparam int unsigned ST_DIR    = 2;
	localparam int unsigned ST_ODD    = 1;
	// flags register fields
	localparam int unsigned FLAG_XFER = 0;
	// endpoint control fields
	localparam int unsigned EPC_HSHK   = 4;
	localparam int unsigned EPC_CONDIS = 3;
	localparam int unsigned EPC_OUTEN  = 2;
	localparam int unsigned EPC_INEN   = 1;
	localparam int unsigned EPC_STALL  = 0;

	localparam logic [4:0]  EP_CTL_RESET   = 5'h00;
	localparam logic [6:0]  DEV_ADDR_RESET = 7'h00;
	localparam logic [10:0] FRAME_RESET    = 11'h000;

	localparam logic [1:0] AXI_OKAY   = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef enum logic [1:0] {TOK_OUT, TOK_IN, TOK_SETUP} token_kind_t;
	typedef enum logic [1:0] {ANS_NONE, ANS_PROCEED, ANS_NAK} answer_kind_t;

	typedef struct packed {
		logic [3:0] ep;
		logic       dir;
		logic       odd;
	} status_entry_t;

	typedef struct packed {
		logic          valid;
		status_entry_t st;
	} xfer_done_t;

	typedef struct packed {
		logic        valid;
		logic [3:0]  ep;
		token_kind_t kind;
	} token_req_t;

	typedef struct packed {
		logic         valid;
		answer_kind_t kind;
		logic         handshake;
	} token_resp_t;

	typedef struct packed {
		logic       valid;
		logic [3:0] ep;
	} stall_evt_t;

	typedef struct packed {
		logic        valid;
		logic [10:0] frame;
	} sof_evt_t;

	typedef struct packed {
		logic       en;
		logic       we;
		logic       desc_sel;
		logic [5:0] desc_num;
		logic [1:0] desc_field;
		logic [9:0] addr;
		logic [7:0] wdata;
	} eng_ram_req_t;
endpackage

// ---- rtl/usb_ram_dp.sv ----
// module: one kilobyte dual port byte memory shared by core and serial engine
// assumes both ports on mclk; contents are not cleared by reset
`timescale 1ns/10ps
module usb_ram_dp (
	input  wire logic       mclk,
	input  wire logic       resetn,
	input  wire logic       a_en,
	input  wire logic       a_we,
	input  wire logic [9:0] a_addr,
	input  wire logic [7:0] a_wdata,
	output logic      [7:0] a_rdata,
	input  wire logic       b_en,
	input  wire logic       b_we,
	input  wire logic [9:0] b_addr,
	input  wire logic [7:0] b_wdata,
	output logic      [7:0] b_rdata
);
	logic [7:0] mem [0:1023];

	// same-address writes on both ports: port b lands last
	always_ff @(posedge mclk) begin
		if (a_en && a_we) begin
			mem[a_addr] <= a_wdata;
		end
		if (b_en && b_we) begin
			mem[b_addr] <= b_wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			a_rdata <= 8'h00;
			b_rdata <= 8'h00;
		end else begin
			if (a_en) begin
				a_rdata <= mem[a_addr];
			end
			if (b_en) begin
				b_rdata <= mem[b_addr];
			end
		end
	end
endmodule

// ---- rtl/usb_bookkeeping.sv ----
// module: status queue, endpoint control, address, frame number and buffer memory
// assumes an axi4-lite master on mclk and a serial engine on the same clock
`timescale 1ns/10ps
module usb_bookkeeping (
	input  wire logic                       mclk,
	input  wire logic                       resetn,
	input  wire logic [12:0]                s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [12:0]                s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire usb_bk_pkg::xfer_done_t     xfer_done,
	input  wire usb_bk_pkg::token_req_t     token_req,
	output usb_bk_pkg::token_resp_t         token_resp,
	input  wire usb_bk_pkg::stall_evt_t     stall_evt,
	input  wire usb_bk_pkg::sof_evt_t       sof_evt,
	input  wire logic                       bus_reset,
	input  wire usb_bk_pkg::eng_ram_req_t   eng_ram,
	output logic [7:0]                      eng_ram_rdata,
	output logic [6:0]                      device_address,
	output logic [15:0]                     endpoint_live,
	output logic                            transfer_complete_flag
);
	typedef struct packed {
		logic [15:0][4:0]                  ep_ctl;
		logic [6:0]                        dev_addr;
		logic [10:0]                       frame;
		usb_bk_pkg::status_entry_t [3:0]   fifo;
		logic [1:0]                        rd_ptr;
		logic [2:0]                        count;
		logic                              flag;
		usb_bk_pkg::token_resp_t           resp;
		logic [15:0]                       live;
		logic                              aw_held;
		logic [12:0]                       aw_addr;
		logic                              w_held;
		logic [7:0]                        w_data;
		logic                              w_lane0;
		logic                              awready;
		logic                              wready;
		logic                              bvalid;
		logic [1:0]                        bresp;
		logic                              rd_stage;
		logic [12:0]                       ar_addr;
		logic                              arready;
		logic                              rvalid;
		logic [1:0]                        rresp;
		logic [7:0]                        rdata;
	} state_t;

	localparam int REFLAG_MAX = usb_bk_pkg::REFLAG_CYCLES;

	state_t      s_reg;
	state_t      s_next;
	logic        aw_hs;
	logic        w_hs;
	logic        ar_hs;
	logic        commit;
	logic [10:0] w_idx;
	logic [10:0] r_idx;
	logic        pop;
	logic [4:0]  tok_ctl;
	logic        dir_ok;
	logic        c_en;
	logic        c_we;
	logic [9:0]  c_addr;
	logic [7:0]  ram_q;
	logic [9:0]  eng_addr;
	usb_bk_pkg::status_entry_t head;

	function automatic logic in_ram(input logic [10:0] idx);
		return idx >= usb_bk_pkg::RAM_FIRST_IDX && idx <= usb_bk_pkg::RAM_LAST_IDX;
	endfunction

	function automatic logic is_ep(input logic [10:0] idx);
		return idx[10:4] == usb_bk_pkg::OFF_EP_CTL[12:6];
	endfunction

	function automatic logic reg_hit(input logic [10:0] idx);
		return idx == usb_bk_pkg::OFF_STATUS[12:2] || idx == usb_bk_pkg::OFF_FLAGS[12:2]
			|| idx == usb_bk_pkg::OFF_DEV_ADDR[12:2] || idx == usb_bk_pkg::OFF_FRAME_LO[12:2]
			|| idx == usb_bk_pkg::OFF_FRAME_HI[12:2] || is_ep(idx) || in_ram(idx);
	endfunction

	// descriptor n field f sits at table base plus 4n+f, 64 of them fill 256 bytes
	function automatic logic [9:0] desc_byte(input logic [5:0] num, input logic [1:0] field);
		return {2'b00, num, field};
	endfunction

	assign aw_hs  = s_axi_awvalid && s_reg.awready;
	assign w_hs   = s_axi_wvalid && s_reg.wready;
	assign ar_hs  = s_axi_arvalid && s_reg.arready;
	// a write waits one cycle when a read takes the core memory port
	assign commit = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid && !ar_hs;
	assign w_idx  = s_reg.aw_addr[12:2];
	assign r_idx  = s_reg.ar_addr[12:2];
	assign head   = s_reg.fifo[s_reg.rd_ptr];
	assign pop    = commit && w_idx == usb_bk_pkg::OFF_FLAGS[12:2] && s_reg.w_lane0
		&& s_reg.w_data[usb_bk_pkg::FLAG_XFER] && s_reg.flag;

	assign tok_ctl = s_reg.ep_ctl[token_req.ep];
	always_comb begin
		unique case (token_req.kind)
			usb_bk_pkg::TOK_IN:    dir_ok = tok_ctl[usb_bk_pkg::EPC_INEN];
			usb_bk_pkg::TOK_OUT:   dir_ok = tok_ctl[usb_bk_pkg::EPC_OUTEN];
			usb_bk_pkg::TOK_SETUP: dir_ok = tok_ctl[usb_bk_pkg::EPC_OUTEN]
				&& !(tok_ctl[usb_bk_pkg::EPC_INEN] && tok_ctl[usb_bk_pkg::EPC_CONDIS]);
			default:               dir_ok = 1'b0;
		endcase
	end

	// core port: reads and writes of 400h..7FFh map to memory bytes 0..3FFh
	assign c_en     = ar_hs || (commit && in_ram(w_idx));
	assign c_we     = commit && in_ram(w_idx) && s_reg.w_lane0;
	assign c_addr   = ar_hs ? s_axi_araddr[11:2] : s_reg.aw_addr[11:2];
	assign eng_addr = eng_ram.desc_sel ? desc_byte(eng_ram.desc_num, eng_ram.desc_field)
		: eng_ram.addr;

	usb_ram_dp u_ram (
		.mclk    (mclk),
		.resetn  (resetn),
		.a_en    (c_en),
		.a_we    (c_we),
		.a_addr  (c_addr),
		.a_wdata (s_reg.w_data),
		.a_rdata (ram_q),
		.b_en    (eng_ram.en),
		.b_we    (eng_ram.we),
		.b_addr  (eng_addr),
		.b_wdata (eng_ram.wdata),
		.b_rdata (eng_ram_rdata)
	);

	always_comb begin
		logic [2:0] cnt;
		logic [1:0] ptr;
		cnt    = s_reg.count;
		ptr    = s_reg.rd_ptr;
		s_next = s_reg;

		// write channel capture
		if (aw_hs) begin
			s_next.aw_held = 1'b1;
			s_next.aw_addr = s_axi_awaddr;
		end
		if (w_hs) begin
			s_next.w_held  = 1'b1;
			s_next.w_data  = s_axi_wdata[7:0];
			s_next.w_lane0 = s_axi_wstrb[0];
		end
		if (commit) begin
			s_next.aw_held = 1'b0;
			s_next.w_held  = 1'b0;
			s_next.bvalid  = 1'b1;
			s_next.bresp   = reg_hit(w_idx) ? usb_bk_pkg::AXI_OKAY : usb_bk_pkg::AXI_SLVERR;
			if (s_reg.w_lane0 && w_idx == usb_bk_pkg::OFF_DEV_ADDR[12:2]) begin
				s_next.dev_addr = s_reg.w_data[6:0];
			end
		end
		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
		end

		// endpoint control, engine stall report wins over a software clear
		for (int i = 0; i < usb_bk_pkg::NUM_EP; i++) begin
			if (commit && s_reg.w_lane0 && is_ep(w_idx) && w_idx[3:0] == 4'(i)) begin
				s_next.ep_ctl[i] = s_reg.w_data[4:0];
			end
			if (stall_evt.valid && stall_evt.ep == 4'(i)) begin
				s_next.ep_ctl[i][usb_bk_pkg::EPC_STALL] = 1'b1;
			end
			s_next.live[i] = s_next.ep_ctl[i][usb_bk_pkg::EPC_INEN];
		end

		// status queue; a push in the clearing cycle is queued, never lost
		if (pop) begin
			ptr = ptr + 2'h1;
			cnt = cnt - 3'h1;
		end
		if (xfer_done.valid && cnt != 3'(usb_bk_pkg::FIFO_DEPTH)) begin
			s_next.fifo[2'(ptr + cnt[1:0])] = xfer_done.st;
			cnt = cnt + 3'h1;
		end
		s_next.rd_ptr = ptr;
		s_next.count  = cnt;
		// flag drops for one cycle on a pop, then returns if entries remain
		s_next.flag   = !pop && cnt != 3'h0;

		// token answer
		s_next.resp.valid     = token_req.valid;
		s_next.resp.kind      = usb_bk_pkg::ANS_NONE;
		s_next.resp.handshake = 1'b0;
		if (token_req.valid && dir_ok) begin
			if (s_reg.count == 3'(usb_bk_pkg::FIFO_DEPTH)) begin
				if (tok_ctl[usb_bk_pkg::EPC_HSHK]) begin
					s_next.resp.kind      = usb_bk_pkg::ANS_NAK;
					s_next.resp.handshake = 1'b1;
				end
			end else begin
				s_next.resp.kind      = usb_bk_pkg::ANS_PROCEED;
				s_next.resp.handshake = tok_ctl[usb_bk_pkg::EPC_HSHK];
			end
		end

		if (sof_evt.valid) begin
			s_next.frame = sof_evt.frame;
		end
		if (bus_reset) begin
			s_next.dev_addr = usb_bk_pkg::DEV_ADDR_RESET;
		end

		// read channel: address taken, memory answers next edge, then rvalid
		if (ar_hs) begin
			s_next.rd_stage = 1'b1;
			s_next.ar_addr  = s_axi_araddr;
		end
		if (s_reg.rd_stage) begin
			s_next.rd_stage = 1'b0;
			s_next.rvalid   = 1'b1;
			s_next.rresp    = reg_hit(r_idx) ? usb_bk_pkg::AXI_OKAY : usb_bk_pkg::AXI_SLVERR;
			s_next.rdata    = 8'h00;
			if (in_ram(r_idx)) begin
				s_next.rdata = ram_q;
			end else if (is_ep(r_idx)) begin
				s_next.rdata = {3'b000, s_reg.ep_ctl[r_idx[3:0]]};
			end else if (r_idx == usb_bk_pkg::OFF_STATUS[12:2]) begin
				s_next.rdata[usb_bk_pkg::ST_EP_LSB +: 4] = head.ep;
				s_next.rdata[usb_bk_pkg::ST_DIR]         = head.dir;
				s_next.rdata[usb_bk_pkg::ST_ODD]         = head.odd;
			end else if (r_idx == usb_bk_pkg::OFF_FLAGS[12:2]) begin
				s_next.rdata[usb_bk_pkg::FLAG_XFER] = s_reg.flag;
			end else if (r_idx == usb_bk_pkg::OFF_DEV_ADDR[12:2]) begin
				s_next.rdata = {1'b0, s_reg.dev_addr};
			end else if (r_idx == usb_bk_pkg::OFF_FRAME_LO[12:2]) begin
				s_next.rdata = s_reg.frame[7:0];
			end else if (r_idx == usb_bk_pkg::OFF_FRAME_HI[12:2]) begin
				s_next.rdata = {5'b00000, s_reg.frame[10:8]};
			end
		end
		if (s_reg.rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
		end

		s_next.awready = !s_next.aw_held && !s_next.bvalid;
		s_next.wready  = !s_next.w_held && !s_next.bvalid;
		s_next.arready = !s_next.rd_stage && !s_next.rvalid;

		if (!resetn) begin
			s_next = '0;
			for (int i = 0; i < usb_bk_pkg::NUM_EP; i++) begin
				s_next.ep_ctl[i] = usb_bk_pkg::EP_CTL_RESET;
			end
			s_next.dev_addr = usb_bk_pkg::DEV_ADDR_RESET;
			s_next.frame    = usb_bk_pkg::FRAME_RESET;
		end
	end

	always_ff @(posedge mclk) begin
		s_reg <= s_next;
	end

	assign s_axi_awready          = s_reg.awready;
	assign s_axi_wready           = s_reg.wready;
	assign s_axi_bvalid           = s_reg.bvalid;
	assign s_axi_bresp            = s_reg.bresp;
	assign s_axi_arready          = s_reg.arready;
	assign s_axi_rvalid           = s_reg.rvalid;
	assign s_axi_rresp            = s_reg.rresp;
	assign s_axi_rdata            = {24'h000000, s_reg.rdata};
	assign token_resp             = s_reg.resp;
	assign device_address         = s_reg.dev_addr;
	assign endpoint_live          = s_reg.live;
	assign transfer_complete_flag = s_reg.flag;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	a_status_zero_bits: assert property (
		s_reg.rvalid && r_idx == usb_bk_pkg::OFF_STATUS[12:2]
		|-> s_axi_rdata[7] == 1'b0 && s_axi_rdata[0] == 1'b0 && s_axi_rdata[31:8] == 24'h0)
		else $error("status window reserved bits not zero");

	a_status_head_view: assert property (
		s_reg.rd_stage && r_idx == usb_bk_pkg::OFF_STATUS[12:2]
		|=> s_axi_rdata[6:3] == $past(head.ep) && s_axi_rdata[2] == $past(head.dir))
		else $error("status window does not show queue head");

	a_push_grows_queue: assert property (
		xfer_done.valid && s_reg.count < 3'h4 && !pop
		|=> s_reg.count == $past(s_reg.count) + 3'h1)
		else $error("finished transfer not queued");

	a_reflag_in_time: assert property (
		pop && s_reg.count > 3'h1 |-> ##[1:REFLAG_MAX] s_reg.flag)
		else $error("done flag not raised again after pop");

	a_empty_stays_clear: assert property (
		pop && s_reg.count == 3'h1 && !xfer_done.valid ##1 !xfer_done.valid
		|-> !s_reg.flag ##1 !s_reg.flag)
		else $error("done flag set with empty queue");

	a_full_gets_nak: assert property (
		token_req.valid && dir_ok && s_reg.count == 3'h4 && tok_ctl[usb_bk_pkg::EPC_HSHK]
		|=> token_resp.valid && token_resp.kind == usb_bk_pkg::ANS_NAK)
		else $error("full queue not answered with nak");

	a_no_hshk_quiet: assert property (
		token_req.valid && !tok_ctl[usb_bk_pkg::EPC_HSHK] |=> !token_resp.handshake)
		else $error("handshake given on endpoint without handshake enable");

	a_setup_rejected: assert property (
		token_req.valid && token_req.kind == usb_bk_pkg::TOK_SETUP
		&& tok_ctl[3:1] == 3'h7 |=> token_resp.kind == usb_bk_pkg::ANS_NONE)
		else $error("setup accepted on endpoint with control disabled");

	a_in_disabled: assert property (
		token_req.valid && token_req.kind == usb_bk_pkg::TOK_IN
		&& !tok_ctl[usb_bk_pkg::EPC_INEN] |=> token_resp.kind == usb_bk_pkg::ANS_NONE)
		else $error("in token served on disabled direction");

	a_stall_sticky: assert property (
		stall_evt.valid |=> s_reg.ep_ctl[$past(stall_evt.ep)][usb_bk_pkg::EPC_STALL])
		else $error("stall indicator not set");

	a_bus_reset_addr: assert property (
		bus_reset |=> device_address == 7'h00)
		else $error("device address not cleared by bus reset");

	a_sof_capture: assert property (
		sof_evt.valid |=> s_reg.frame == $past(sof_evt.frame))
		else $error("frame number not captured on sof");
endmodule

// ---- sim/engine_model.sv ----
// serial engine stand-in: pulses finished transfers, tokens, stalls, sof, memory access
// assumes mclk from the bench; every pulse lasts one cycle, payload inverted when idle
`timescale 1ns/10ps
module engine_model (
	input  wire logic                     mclk,
	input  wire logic [7:0]               eng_ram_rdata,
	output usb_bk_pkg::xfer_done_t        xfer_done,
	output usb_bk_pkg::token_req_t        token_req,
	output usb_bk_pkg::stall_evt_t        stall_evt,
	output usb_bk_pkg::sof_evt_t          sof_evt,
	output usb_bk_pkg::eng_ram_req_t      eng_ram,
	output logic                          bus_reset
);
	initial begin
		xfer_done = '0;
		token_req = '0;
		stall_evt = '0;
		sof_evt = '0;
		eng_ram = '0;
		bus_reset = 1'b0;
	end
	task automatic done(input logic [3:0] e, input logic dr, input logic od);
		@(posedge mclk) xfer_done <= {1'b1, e, dr, od};
		@(posedge mclk) xfer_done <= {1'b0, ~e, ~dr, ~od};
	endtask
	task automatic token(input logic [3:0] e, input usb_bk_pkg::token_kind_t k);
		@(posedge mclk) token_req <= {1'b1, e, k};
		@(posedge mclk) token_req <= {1'b0, ~e, ~k};
	endtask
	task automatic stall(input logic [3:0] e);
		@(posedge mclk) stall_evt <= {1'b1, e};
		@(posedge mclk) stall_evt <= {1'b0, ~e};
	endtask
	task automatic sof(input logic [10:0] f);
		@(posedge mclk) sof_evt <= {1'b1, f};
		@(posedge mclk) sof_evt <= {1'b0, ~f};
	endtask
	task automatic brst();
		@(posedge mclk) bus_reset <= 1'b1;
		@(posedge mclk) bus_reset <= 1'b0;
	endtask
	task automatic ram(input logic [27:0] req, output logic [7:0] q);
		@(posedge mclk) eng_ram <= {1'b1, req};
		@(posedge mclk) eng_ram <= {1'b0, ~req};
		#1 q = eng_ram_rdata;
	endtask
endmodule

// ---- sim/tb_top.sv ----
// self-checking bench: axi4-lite master, engine model, queued expectations
// assumes the bookkeeping block with its package compiled first
`timescale 1ns/10ps
module tb_top;
	logic                     mclk, resetn, awv, wv, bready, arv, rready, awr, wr_r, bv, arr, rv;
	logic [12:0]              awa, ara;
	logic [31:0]              wd, rd_d;
	logic [3:0]               ws;
	logic [1:0]               br, rr;
	logic [7:0]               q;
	logic [7:0]               eq;
	logic [6:0]               dev_a;
	logic [15:0]              live;
	logic                     flag;
	usb_bk_pkg::xfer_done_t   xd;
	usb_bk_pkg::token_req_t   tq;
	usb_bk_pkg::token_resp_t  tr;
	usb_bk_pkg::stall_evt_t   se;
	usb_bk_pkg::sof_evt_t     sv;
	usb_bk_pkg::eng_ram_req_t er;
	logic                     brs;
	logic [33:0]              rd_q[$];
	logic [1:0]               wr_q[$];
	usb_bk_pkg::token_resp_t  tok_q[$];
	int                       n_mismatch, num_checks;
	usb_bk_pkg::xfer_done_t   ent[4];
	logic [10:0]              f;
	int                       cnt;
	usb_bk_pkg::token_kind_t  K_IN, K_OUT, K_SU;
	localparam logic [12:0]   FL = usb_bk_pkg::OFF_FLAGS;

	usb_bookkeeping dut_u (.mclk(mclk), .resetn(resetn), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bready), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(rready), .xfer_done(xd), .token_req(tq), .token_resp(tr),
		.stall_evt(se), .sof_evt(sv), .bus_reset(brs), .eng_ram(er),
		.eng_ram_rdata(q), .device_address(dev_a), .endpoint_live(live),
		.transfer_complete_flag(flag));
	engine_model eng_u (.mclk(mclk), .eng_ram_rdata(q), .xfer_done(xd), .token_req(tq),
		.stall_evt(se), .sof_evt(sv), .eng_ram(er), .bus_reset(brs));

	task automatic cmp(input logic [33:0] g, input logic [33:0] e);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cmp_tok(input usb_bk_pkg::token_resp_t g, input usb_bk_pkg::token_resp_t e);
		cmp(34'(g), 34'(e));
	endtask
	task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic [1:0] r);
		logic ao, wo;
		ao = 0;
		wo = 0;
		wr_q.push_back(r);
		@(posedge mclk) {awa, wd, ws, awv, wv, bready} <= {a, 24'h0, d, 4'h1, 3'b111};
		while (!(ao && wo)) begin
			@(posedge mclk);
			if (!ao && awr === 1'b1) begin
				ao = 1;
				awv <= 1'b0;
			end
			if (!wo && wr_r === 1'b1) begin
				wo = 1;
				wv <= 1'b0;
			end
		end
		do @(posedge mclk); while (bv !== 1'b1);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [12:0] a, input logic [7:0] d, input logic [1:0] r);
		rd_q.push_back({r, 24'h0, d});
		@(posedge mclk) {ara, arv, rready} <= {a, 2'b11};
		do @(posedge mclk); while (arr !== 1'b1);
		arv <= 1'b0;
		do @(posedge mclk); while (rv !== 1'b1);
		rready <= 1'b0;
	endtask
	task automatic tok(input logic [3:0] e, input usb_bk_pkg::token_kind_t k,
			input usb_bk_pkg::answer_kind_t x, input logic h);
		tok_q.push_back({1'b1, x, h});
		eng_u.token(e, k);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge mclk) begin
		if (rv === 1'b1 && rready === 1'b1)
			cmp({rr, rd_d}, rd_q.pop_front());
		if (bv === 1'b1 && bready === 1'b1)
			cmp(34'(br), 34'(wr_q.pop_front()));
		if (tr.valid === 1'b1)
			cmp_tok(tr, tok_q.pop_front());
	end
	initial begin
		mclk = 0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		#200us;
		n_mismatch++;
		complete_run();
	end
	initial begin
		{resetn, awv, wv, bready, arv, rready, awa, ara, wd, ws} = '0;
		K_IN = usb_bk_pkg::TOK_IN;
		K_OUT = usb_bk_pkg::TOK_OUT;
		K_SU = usb_bk_pkg::TOK_SETUP;
		void'($urandom(32'h4928));
		repeat (16) @(posedge mclk);
		resetn <= 1'b1;
		repeat (2) @(posedge mclk);
		for (int i = 0; i < 16; i++)
			rd(usb_bk_pkg::OFF_EP_CTL + 13'(4 * i), 8'h00, 2'h0);
		rd(usb_bk_pkg::OFF_DEV_ADDR, 8'h00, 2'h0);
		wr(usb_bk_pkg::OFF_EP_CTL + 13'h3c, 8'hff, 2'h0);
		rd(usb_bk_pkg::OFF_EP_CTL + 13'h3c, 8'h1f, 2'h0);
		rd(13'h0020, 8'h00, usb_bk_pkg::AXI_SLVERR);
		$display("test registers done");
		wr(usb_bk_pkg::OFF_EP_CTL + 13'h14, 8'h16, 2'h0);
		cmp(34'(live[5]), 34'h1);
		tok(4'h5, K_IN, usb_bk_pkg::ANS_PROCEED, 1'b1);
		tok(4'h5, K_SU, usb_bk_pkg::ANS_PROCEED, 1'b1);
		for (int i = 0; i < 4; i++) begin
			ent[i] = 7'($urandom);
			eng_u.done(ent[i].st.ep, ent[i].st.dir, ent[i].st.odd);
		end
		cmp(34'(flag), 34'h1);
		tok(4'h5, K_OUT, usb_bk_pkg::ANS_NAK, 1'b1);
		wr(usb_bk_pkg::OFF_EP_CTL + 13'h14, 8'h06, 2'h0);
		tok(4'h5, K_IN, usb_bk_pkg::ANS_NONE, 1'b0);
		wr(usb_bk_pkg::OFF_EP_CTL + 13'h14, 8'h1e, 2'h0);
		tok(4'h5, K_SU, usb_bk_pkg::ANS_NONE, 1'b0);
		wr(usb_bk_pkg::OFF_EP_CTL + 13'h14, 8'h12, 2'h0);
		tok(4'h5, K_OUT, usb_bk_pkg::ANS_NONE, 1'b0);
		tok(4'h0, K_IN, usb_bk_pkg::ANS_NONE, 1'b0);
		for (int i = 0; i < 4; i++) begin
			rd(usb_bk_pkg::OFF_STATUS, {1'b0, ent[i].st, 1'b0}, 2'h0);
			rd(FL, 8'h01, 2'h0);
			wr(FL, 8'h01, 2'h0);
			cnt = 0;
			while (i < 3 && flag !== 1'b1 && cnt < 40) begin
				@(posedge mclk);
				cnt++;
			end
			cmp(34'(cnt <= usb_bk_pkg::REFLAG_CYCLES), 34'h1);
		end
		repeat (10) @(posedge mclk);
		cmp(34'(flag), 34'h0);
		$display("test status queue done");
		eng_u.stall(4'h5);
		rd(usb_bk_pkg::OFF_EP_CTL + 13'h14, 8'h13, 2'h0);
		wr(usb_bk_pkg::OFF_EP_CTL + 13'h14, 8'h12, 2'h0);
		rd(usb_bk_pkg::OFF_EP_CTL + 13'h14, 8'h12, 2'h0);
		f = 11'($urandom);
		eng_u.sof(f);
		wr(usb_bk_pkg::OFF_FRAME_LO, ~f[7:0], 2'h0);
		rd(usb_bk_pkg::OFF_FRAME_LO, f[7:0], 2'h0);
		rd(usb_bk_pkg::OFF_FRAME_HI, {5'h0, f[10:8]}, 2'h0);
		wr(usb_bk_pkg::OFF_DEV_ADDR, {1'b0, f[6:0]}, 2'h0);
		cmp(34'(dev_a), 34'(f[6:0]));
		eng_u.brst();
		rd(usb_bk_pkg::OFF_DEV_ADDR, 8'h00, 2'h0);
		$display("test engine events done");
		wr(13'h1038, f[7:0], 2'h0);
		eng_u.ram({1'b0, 1'b1, 6'd3, 2'd2, 10'h0, 8'h0}, eq);
		cmp(34'(eq), 34'(f[7:0]));
		eng_u.ram({1'b1, 1'b0, 6'd0, 2'd0, 10'h300, ~f[7:0]}, eq);
		rd(13'h1c00, ~f[7:0], 2'h0);
		wr(13'h13fc, 8'h5a, 2'h0);
		eng_u.ram({1'b0, 1'b1, 6'd63, 2'd3, 10'h0, 8'h0}, eq);
		cmp(34'(eq), 34'h5a);
		$display("test buffer memory done");
		repeat (4) @(posedge mclk);
		complete_run();
	end
endmodule
